// >>> src/bus_master_regs.vh
`ifndef BUS_MASTER_REGS_VH
`define BUS_MASTER_REGS_VH

// register byte offsets
`define OFS_CTRL     8'h00
`define OFS_CMD      8'h04
`define OFS_ADDR     8'h08
`define OFS_WDATA    8'h0C
`define OFS_STATUS   8'h10
`define OFS_RDATA    8'h14
`define OFS_INT_STAT 8'h18
`define OFS_INT_MASK 8'h1C

// control register fields
`define CTRL_BCLK_EN  0
`define CTRL_CCLK_EN  1
`define CTRL_INIT_DRV 2
`define CTRL_INIT_RX  3
`define CTRL_HI_ADR   4
`define CTRL_PARK     5
`define CTRL_RST      6'h00

// command register fields
`define CMD_GO    0
`define CMD_WRITE 1
`define CMD_IO    2
`define CMD_BYTE  3

// status register fields
`define STAT_BUSY  0
`define STAT_OWN   1
`define STAT_TMO   2
`define STAT_SUPLO 3
`define STAT_DMA   4

// interrupt status and mask fields
`define INT_DONE  0
`define INT_TMO   1
`define INT_DMAWR 2
`define INT_SUPLO 3

// timing
`define CLK_KHZ 20000
`define TMO_NS  12000
`define TMO_CYC ((`TMO_NS * `CLK_KHZ) / 1000000)

// axi response codes
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> src/bus_master_if.v
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "bus_master_regs.vh"

module bus_master_if #(
    parameter MEM_AW   = 8,
    parameter DMA_BASE = 11'h000
) (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         irq,
    output reg  [23:0] adr_o,
    output reg         adr_lo_oe_n,
    output reg         adr_hi_oe_n,
    input  wire [23:0] adr_i,
    output reg  [15:0] dat_o,
    output reg         dat_oe_n,
    input  wire [15:0] dat_i,
    output reg         mwtc_n_o,
    output reg         mrdc_n_o,
    output reg         iowc_n_o,
    output reg         iorc_n_o,
    output reg         cmd_oe_n,
    input  wire        mwtc_n_i,
    input  wire        mrdc_n_i,
    output reg         bhen_n_o,
    output reg         bhen_oe_n,
    output reg         xack_n_o,
    output reg         xack_oe_n,
    input  wire        xack_n_i,
    output reg         breq_n,
    input  wire        bprn_n,
    output reg         busy_n_o,
    output reg         busy_oe_n,
    input  wire        busy_n_i,
    output reg         bclk_o,
    output reg         bclk_oe_n,
    output reg         cclk_o,
    output reg         cclk_oe_n,
    output reg         init_n_o,
    output reg         init_oe_n,
    input  wire        init_n_i,
    input  wire        supply_low,
    output reg         core_reset
);

    localparam S_IDLE = 6'h01;
    localparam S_ARB  = 6'h02;
    localparam S_SET  = 6'h04;
    localparam S_CMD  = 6'h08;
    localparam S_END  = 6'h10;
    localparam S_DACK = 6'h20;
    localparam [31:0] TMO_LAST = `TMO_CYC - 1;

    // two-flop synchronisers; reset to idle levels, so no false edge
    reg [46:0] sy1_q;
    reg [46:0] sy2_q;
    wire [46:0] sy_in = {adr_i, dat_i, mwtc_n_i, mrdc_n_i, xack_n_i,
                         bprn_n, busy_n_i, init_n_i, supply_low};
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sy1_q <= {{46{1'b1}}, 1'b0};
            sy2_q <= {{46{1'b1}}, 1'b0};
        end else begin
            sy1_q <= sy_in;
            sy2_q <= sy1_q;
        end
    end
    wire [23:0] adr_s   = sy2_q[46:23];
    wire [15:0] dat_s   = sy2_q[22:7];
    wire        mwtc_s  = sy2_q[6];
    wire        mrdc_s  = sy2_q[5];
    wire        xack_s  = sy2_q[4];
    wire        bprn_s  = sy2_q[3];
    wire        busy_s  = sy2_q[2];

    // software-visible registers and internal engine state
    reg [5:0]  ctrl_q;
    reg [3:0]  cmd_q;
    reg [23:0] addr_q;
    reg [15:0] wdata_q;
    reg [15:0] rdata_q;
    reg [3:0]  int_stat_q;
    reg [3:0]  int_mask_q;
    reg        go_q;
    reg        tmo_q;
    reg        own_q;
    reg [5:0]  st_q;
    reg [7:0]  cnt_q;
    reg        ev_done_q;
    reg        ev_tmo_q;
    reg        ev_dma_q;
    reg        suplo_q;
    reg [7:0]  awaddr_q;
    reg [31:0] wbuf_q;
    reg [15:0] mem [0:(1<<MEM_AW)-1];

    wire do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire [3:0] int_clr = (do_wr && awaddr_q == `OFS_INT_STAT) ?
                         wbuf_q[3:0] : 4'h0;
    wire busy_cyc = (st_q != S_IDLE) & (st_q != S_DACK);

    // axi write channels, taken in either order, answered after both
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            awaddr_q      <= 8'h00;
            wbuf_q        <= 32'h0000_0000;
            ctrl_q        <= `CTRL_RST;
            cmd_q         <= 4'h0;
            addr_q        <= 24'h00_0000;
            wdata_q       <= 16'h0000;
            int_mask_q    <= 4'h0;
            go_q          <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wbuf_q       <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (awaddr_q)
                    `OFS_CTRL:     ctrl_q <= wbuf_q[5:0];
                    `OFS_ADDR:     addr_q <= wbuf_q[23:0];
                    `OFS_WDATA:    wdata_q <= wbuf_q[15:0];
                    `OFS_INT_MASK: int_mask_q <= wbuf_q[3:0];
                    `OFS_INT_STAT: ;
                    `OFS_CMD: begin
                        // a command while a cycle runs is dropped
                        if (!busy_cyc) begin
                            cmd_q <= wbuf_q[3:0];
                            go_q  <= wbuf_q[`CMD_GO];
                        end
                    end
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // axi read channel, data one cycle after the address is taken
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `RESP_OKAY;
                case (s_axi_araddr)
                    `OFS_CTRL:     s_axi_rdata <= {26'h0, ctrl_q};
                    `OFS_CMD:      s_axi_rdata <= {28'h0, cmd_q};
                    `OFS_ADDR:     s_axi_rdata <= {8'h00, addr_q};
                    `OFS_WDATA:    s_axi_rdata <= {16'h0000, wdata_q};
                    `OFS_STATUS:   s_axi_rdata <= {27'h0,
                        st_q == S_DACK, suplo_q, tmo_q, own_q, busy_cyc};
                    `OFS_RDATA:    s_axi_rdata <= {16'h0000, rdata_q};
                    `OFS_INT_STAT: s_axi_rdata <= {28'h0, int_stat_q};
                    `OFS_INT_MASK: s_axi_rdata <= {28'h0, int_mask_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            int_stat_q <= 4'h0;
            irq        <= 1'b0;
            suplo_q    <= 1'b0;
        end else begin
            suplo_q    <= sy2_q[0];
            int_stat_q <= (int_stat_q & ~int_clr) |
                {sy2_q[0] & ~suplo_q, ev_dma_q, ev_tmo_q, ev_done_q};
            irq        <= |(int_stat_q & int_mask_q);
        end
    end

    // clock sourcing and initialize handling
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bclk_o     <= 1'b0;
            cclk_o     <= 1'b0;
            bclk_oe_n  <= 1'b1;
            cclk_oe_n  <= 1'b1;
            init_n_o   <= 1'b0;
            init_oe_n  <= 1'b1;
            core_reset <= 1'b1;
        end else begin
            bclk_o    <= ~bclk_o;
            cclk_o    <= ~cclk_o;
            bclk_oe_n <= ~ctrl_q[`CTRL_BCLK_EN];
            cclk_oe_n <= ~ctrl_q[`CTRL_CCLK_EN];
            init_n_o  <= 1'b0;
            init_oe_n <= ~(sy2_q[0] & ctrl_q[`CTRL_INIT_DRV]);
            core_reset <= sy2_q[0] | (ctrl_q[`CTRL_INIT_RX] & ~sy2_q[1]);
        end
    end

    // master cycle engine and dma slave share the data drivers and the
    // state register, so both live in one process
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q        <= S_IDLE;
            cnt_q       <= 8'h00;
            own_q       <= 1'b0;
            tmo_q       <= 1'b0;
            rdata_q     <= 16'h0000;
            ev_done_q   <= 1'b0;
            ev_tmo_q    <= 1'b0;
            ev_dma_q    <= 1'b0;
            breq_n      <= 1'b1;
            busy_n_o    <= 1'b0;
            busy_oe_n   <= 1'b1;
            adr_o       <= 24'h00_0000;
            adr_lo_oe_n <= 1'b1;
            adr_hi_oe_n <= 1'b1;
            dat_o       <= 16'h0000;
            dat_oe_n    <= 1'b1;
            mwtc_n_o    <= 1'b1;
            mrdc_n_o    <= 1'b1;
            iowc_n_o    <= 1'b1;
            iorc_n_o    <= 1'b1;
            cmd_oe_n    <= 1'b1;
            bhen_n_o    <= 1'b1;
            bhen_oe_n   <= 1'b1;
            xack_n_o    <= 1'b0;
            xack_oe_n   <= 1'b1;
        end else begin
            ev_done_q <= 1'b0;
            ev_tmo_q  <= 1'b0;
            ev_dma_q  <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (go_q) begin
                        st_q <= own_q ? S_SET : S_ARB;
                        breq_n <= own_q;
                    end else if (own_q && !ctrl_q[`CTRL_PARK]) begin
                        own_q     <= 1'b0;
                        busy_oe_n <= 1'b1;
                    end else if (!own_q && (!mwtc_s || !mrdc_s) &&
                                 adr_s[19:MEM_AW+1] == DMA_BASE) begin
                        if (!mwtc_s) begin
                            mem[adr_s[MEM_AW:1]] <= dat_s;
                            ev_dma_q <= 1'b1;
                        end else begin
                            dat_o    <= mem[adr_s[MEM_AW:1]];
                            dat_oe_n <= 1'b0;
                        end
                        xack_oe_n <= 1'b0;
                        st_q      <= S_DACK;
                    end
                end
                S_ARB: begin
                    if (!bprn_s && busy_s) begin
                        own_q     <= 1'b1;
                        busy_oe_n <= 1'b0;
                        breq_n    <= 1'b1;
                        st_q      <= S_SET;
                    end
                end
                S_SET: begin
                    adr_o       <= addr_q;
                    adr_lo_oe_n <= 1'b0;
                    adr_hi_oe_n <= ~ctrl_q[`CTRL_HI_ADR];
                    bhen_n_o  <= cmd_q[`CMD_BYTE] & ~addr_q[0];
                    bhen_oe_n <= 1'b0;
                    dat_o    <= wdata_q;
                    dat_oe_n <= ~cmd_q[`CMD_WRITE];
                    mwtc_n_o <= ~(cmd_q[`CMD_WRITE] & ~cmd_q[`CMD_IO]);
                    mrdc_n_o <= ~(~cmd_q[`CMD_WRITE] & ~cmd_q[`CMD_IO]);
                    iowc_n_o <= ~(cmd_q[`CMD_WRITE] & cmd_q[`CMD_IO]);
                    iorc_n_o <= ~(~cmd_q[`CMD_WRITE] & cmd_q[`CMD_IO]);
                    cmd_oe_n <= 1'b0;
                    cnt_q    <= 8'h00;
                    st_q     <= S_CMD;
                end
                S_CMD: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (!xack_s) begin
                        rdata_q   <= dat_s;
                        tmo_q     <= 1'b0;
                        ev_done_q <= 1'b1;
                        st_q      <= S_END;
                    end else if (cnt_q == TMO_LAST[7:0]) begin
                        tmo_q    <= 1'b1;
                        ev_tmo_q <= 1'b1;
                        st_q     <= S_END;
                    end
                end
                S_END: begin
                    mwtc_n_o    <= 1'b1;
                    mrdc_n_o    <= 1'b1;
                    iowc_n_o    <= 1'b1;
                    iorc_n_o    <= 1'b1;
                    cmd_oe_n    <= 1'b1;
                    dat_oe_n    <= 1'b1;
                    adr_lo_oe_n <= 1'b1;
                    adr_hi_oe_n <= 1'b1;
                    bhen_oe_n   <= 1'b1;
                    if (!ctrl_q[`CTRL_PARK]) begin
                        own_q     <= 1'b0;
                        busy_oe_n <= 1'b1;
                    end
                    if (mwtc_s && mrdc_s) st_q <= S_IDLE; // own echo gone
                end
                S_DACK: begin
                    // hold acknowledge until the master lifts its strobe
                    if (mwtc_s && mrdc_s) begin
                        xack_oe_n <= 1'b1;
                        dat_oe_n  <= 1'b1;
                        st_q      <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

endmodule // bus_master_if

// >>> verification/bus_master_chk.sv
`timescale 1ns/1ps
module bus_master_chk (
    input wire clk_sys,
    input wire rst,
    input wire mwtc_n_o,
    input wire mrdc_n_o,
    input wire iowc_n_o,
    input wire iorc_n_o,
    input wire cmd_oe_n,
    input wire busy_oe_n,
    input wire breq_n,
    input wire xack_n_i,
    input wire xack_n_o,
    input wire xack_oe_n,
    input wire adr_lo_oe_n,
    input wire bhen_oe_n,
    input wire bclk_o,
    input wire bclk_oe_n,
    input wire cclk_o,
    input wire cclk_oe_n,
    input wire supply_low,
    input wire core_reset
);
    wire       strb = !(mwtc_n_o & mrdc_n_o & iowc_n_o & iorc_n_o);
    reg  [8:0] low_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // cycles the current strobe has been low
    always @(posedge clk_sys or posedge rst)
        if (rst) low_q <= 9'h000;
        else low_q <= strb ? low_q + 9'h001 : 9'h000;
    sequence no_ack; xack_n_i [*4]; endsequence
    sequence young; strb && low_q < 9'h0C8; endsequence
    strb_hold_a: assert property ((no_ack ##0 young) |=> strb)
        else $error("strobe dropped without ack");
    tmo_bound_a: assert property (strb |-> low_q < 9'h0F2)
        else $error("strobe outlived timeout");
    strb_own_a: assert property (strb |-> !busy_oe_n && !adr_lo_oe_n
        && !cmd_oe_n)
        else $error("strobe without bus ownership");
    own_req_a: assert property ($fell(busy_oe_n) |-> $past(!breq_n))
        else $error("bus taken without request");
    strb_one_a: assert property ($onehot0({!mwtc_n_o, !mrdc_n_o,
        !iowc_n_o, !iorc_n_o}))
        else $error("two strobes at once");
    bclk_run_a: assert property (!bclk_oe_n && $past(!bclk_oe_n)
        |-> bclk_o != $past(bclk_o))
        else $error("bus clock not toggling");
    cclk_run_a: assert property (!cclk_oe_n && $past(!cclk_oe_n)
        |-> cclk_o != $past(cclk_o))
        else $error("constant clock not toggling");
    sup_rst_a: assert property (supply_low [*4] |-> core_reset)
        else $error("low supply without reset");
    dma_ack_a: assert property (!xack_oe_n |-> busy_oe_n && !xack_n_o)
        else $error("slave ack while owning bus");
    bhen_own_a: assert property (!bhen_oe_n |-> !busy_oe_n)
        else $error("byte enable without ownership");
endmodule // bus_master_chk
bind bus_master_if bus_master_chk u_chk (.*);

// >>> verification/bus_far_end.sv
`timescale 1ns/1ps
module bus_far_end (
    input  wire        clk_sys,
    input  wire        breq_n,
    input  wire        busy_oe_n,
    input  wire        cmd_oe_n,
    input  wire [3:0]  strb_n,
    input  wire [23:0] adr_o,
    input  wire        adr_lo_oe_n,
    input  wire [15:0] dat_o,
    input  wire        dat_oe_n,
    input  wire        xack_oe_n,
    output reg         bprn_n,
    output wire        busy_n_i,
    output wire        xack_n_i,
    output wire [15:0] dat_i,
    output wire [23:0] adr_i,
    output wire        mwtc_n_i,
    output wire        mrdc_n_i
);
    integer    ack_dly = 3; // zero: the slave never answers
    reg [7:0]  wait_q = 8'h00;
    reg [15:0] mem_q = 16'h0000, pat_q = 16'h5A3C, dma_dat = 16'h0000;
    reg [23:0] dma_adr = 24'h000000;
    reg        dma_wr_n = 1'h1, dma_rd_n = 1'h1, dma_drv = 1'h0;
    wire       idle = &strb_n | cmd_oe_n;
    wire       rd = !strb_n[2] | !strb_n[0];
    // grant follows request; pulled-up busy held only by the device
    always @(posedge clk_sys) bprn_n <= breq_n;
    assign busy_n_i = busy_oe_n;
    // ack stays low until the strobe is removed
    assign xack_n_i = xack_oe_n &
        !(ack_dly != 0 && !idle && wait_q >= ack_dly);
    // released data lines show a pattern that never settles
    assign dat_i = !dat_oe_n ? dat_o : dma_drv ? dma_dat :
        (!idle && rd) ? mem_q : pat_q;
    assign adr_i = !(dma_wr_n & dma_rd_n) ? dma_adr :
        adr_lo_oe_n ? ~adr_o : adr_o;
    assign mwtc_n_i = dma_wr_n & (cmd_oe_n | strb_n[3]);
    assign mrdc_n_i = dma_rd_n & (cmd_oe_n | strb_n[2]);
    // slave wait count and write capture
    always @(posedge clk_sys) begin
        pat_q <= ~pat_q;
        wait_q <= idle ? 8'h00 : wait_q + {7'h00, wait_q != 8'hFF};
        if (!idle && !rd && wait_q == 8'h01) mem_q <= dat_o;
    end
    // other master's command held until the device acknowledges
    task dma(input wr, input [23:0] a, input [15:0] d, output [15:0] q);
        integer n;
        begin
            @(posedge clk_sys);
            dma_adr <= a;
            dma_dat <= d;
            dma_drv <= wr;
            dma_wr_n <= !wr;
            dma_rd_n <= wr;
            n = 0;
            do begin
                @(posedge clk_sys);
                n = n + 1;
            end while (xack_n_i && n < 50);
            q = dat_i;
            dma_wr_n <= 1'h1;
            dma_rd_n <= 1'h1;
            dma_drv <= 1'h0;
            repeat (6) @(posedge clk_sys);
        end
    endtask
endmodule // bus_far_end

// >>> verification/ieee796_bus_master_interface_tb_top.sv
`timescale 1ns/1ps
`include "bus_master_regs.vh"
`define CHK(g, e, m) begin tests_run = tests_run + 1; if ((g) !== (e)) \
begin failures = failures + 1; $display("FAIL %0t %s", $time, m); end end
module ieee796_bus_master_interface_tb_top;
    reg         clk_sys, rst, aw_v, w_v, b_r, ar_v, r_r, supply_low;
    reg         init_tb_n, c_bh, c_hoe;
    reg  [7:0]  aw_a, ar_a;
    reg  [31:0] w_d, rd;
    reg  [23:0] c_adr, ta;
    reg  [15:0] c_dat, q;
    reg  [3:0]  c_strb;
    integer     failures, tests_run, c_len, i;
    wire        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq, adr_lo_oe_n;
    wire [1:0]  b_resp, r_resp;
    wire [31:0] r_dat;
    wire [23:0] adr_o, adr_i;
    wire [15:0] dat_o, dat_i;
    wire        adr_hi_oe_n, dat_oe_n, mwtc_n_o, mrdc_n_o, iowc_n_o;
    wire        iorc_n_o, cmd_oe_n, mwtc_n_i, mrdc_n_i, bhen_n_o, busy_n_i;
    wire        bhen_oe_n, xack_n_o, xack_oe_n, xack_n_i, breq_n, bprn_n;
    wire        busy_n_o, busy_oe_n, bclk_o, bclk_oe_n, cclk_o, cclk_oe_n;
    wire        init_n_o, init_oe_n, core_reset;
    wire [3:0]  strb_n = {mwtc_n_o, mrdc_n_o, iowc_n_o, iorc_n_o};
    // wired initialize line that the other party may pull low
    wire        init_n_i = init_tb_n & (init_oe_n | init_n_o);
    bus_master_if u_bus_master_if (.*, .s_axi_awaddr(aw_a),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld), .s_axi_bready(b_r),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_dat), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld),
        .s_axi_rready(r_r));
    bus_far_end u_bus_far_end (.*);
    // register write: address and data offered together, bready held
    task axw(input [7:0] a, input [31:0] d, input [1:0] er);
        integer n;
        begin
            @(posedge clk_sys);
            aw_a <= a;
            w_d <= d;
            aw_v <= 1'h1;
            w_v <= 1'h1;
            b_r <= 1'h1;
            n = 0;
            do begin
                @(posedge clk_sys);
                n = n + 1;
                if (aw_rdy) aw_v <= 1'h0;
                if (w_rdy) w_v <= 1'h0;
            end while (!b_vld && n < 100);
            b_r <= 1'h0;
            `CHK(b_resp, er, "write response")
        end
    endtask
    task axr(input [7:0] a, input [1:0] er);
        integer n;
        begin
            @(posedge clk_sys);
            ar_a <= a;
            ar_v <= 1'h1;
            r_r <= 1'h1;
            n = 0;
            do begin
                @(posedge clk_sys);
                n = n + 1;
                if (ar_rdy) ar_v <= 1'h0;
            end while (!r_vld && n < 100);
            r_r <= 1'h0;
            rd = r_dat;
            `CHK(r_resp, er, "read response")
        end
    endtask
    // one master cycle; records what the bus showed under the strobe
    task cyc(input [3:0] cmd, input [23:0] a, input [15:0] d);
        integer n;
        begin
            axw(`OFS_ADDR, {8'h00, a}, `RESP_OKAY);
            axw(`OFS_WDATA, {16'h0000, d}, `RESP_OKAY);
            axw(`OFS_CMD, {28'h0000000, cmd}, `RESP_OKAY);
            n = 0;
            while (&strb_n && n < 60) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            c_strb = strb_n;
            c_bh = bhen_n_o;
            c_hoe = adr_hi_oe_n;
            c_adr = adr_o;
            c_dat = dat_o;
            c_len = 0;
            while (!(&strb_n) && c_len < 400) begin
                @(posedge clk_sys);
                c_len = c_len + 1;
            end
            repeat (4) @(posedge clk_sys);
        end
    endtask
    task t_reset;
        begin
            `CHK({cmd_oe_n, busy_oe_n, bclk_oe_n, init_oe_n}, 4'hF, "idle")
            axr(`OFS_CTRL, `RESP_OKAY);
            `CHK(rd, 32'h00000000, "ctrl reset")
            axr(8'h40, `RESP_SLVERR);
            axw(8'h44, 32'h00000001, `RESP_SLVERR);
            $display("done reset");
        end
    endtask
    task t_kinds;
        for (i = 0; i < 4; i = i + 1) begin
            ta = {20'h5A2C4, i[2:0], 1'h0};
            cyc({1'h0, i[1], !i[0], 1'h1}, ta, {12'h123, i[3:0]});
            `CHK(c_strb, ~(4'h8 >> i), "strobe kind")
            `CHK(c_adr[19:0], ta[19:0], "low address")
            `CHK(c_hoe, 1'h1, "high lines cut")
            `CHK(c_len >= 4 && c_len <= 9, 1'h1, "ack wait")
            `CHK(c_bh, 1'h0, "word enable")
            if (!i[0]) `CHK(u_bus_far_end.mem_q, {12'h123, i[3:0]}, "wr")
            if (i[0]) axr(`OFS_RDATA, `RESP_OKAY);
            if (i[0]) `CHK(rd[15:0], {12'h123, i[3:0] - 4'h1}, "rd")
        end
        $display("done kinds");
    endtask
    task t_byte;
        for (i = 0; i < 2; i = i + 1) begin
            cyc(4'hB, {23'h000080, i[0]}, 16'h00C3);
            `CHK(c_bh, !i[0], "byte enable")
        end
        $display("done byte");
    endtask
    task t_hi;
        begin
            axw(`OFS_CTRL, 32'h00000030, `RESP_OKAY);
            cyc(4'h1, 24'hA50102, 16'h0000);
            `CHK({c_hoe, c_adr}, {1'h0, 24'hA50102}, "full address")
            `CHK(busy_oe_n, 1'h0, "bus parked")
            axw(`OFS_CTRL, 32'h00000000, `RESP_OKAY);
            @(posedge clk_sys);
            `CHK(busy_oe_n, 1'h1, "bus freed")
            $display("done high address");
        end
    endtask
    task t_tmo;
        begin
            u_bus_far_end.ack_dly = 0;
            cyc(4'h1, 24'h000200, 16'h0000);
            `CHK(c_len >= 240 && c_len <= 242, 1'h1, "timeout")
            axr(`OFS_STATUS, `RESP_OKAY);
            `CHK(rd[`STAT_TMO], 1'h1, "timeout flag")
            axr(`OFS_INT_STAT, `RESP_OKAY);
            `CHK({rd[`INT_TMO], irq}, 2'h2, "masked")
            axw(`OFS_INT_MASK, 32'h00000002, `RESP_OKAY);
            repeat (2) @(posedge clk_sys);
            `CHK(irq, 1'h1, "irq raised")
            axw(`OFS_INT_STAT, 32'h00000003, `RESP_OKAY);
            repeat (2) @(posedge clk_sys);
            `CHK(irq, 1'h0, "irq cleared")
            axw(`OFS_INT_MASK, 32'h00000000, `RESP_OKAY);
            u_bus_far_end.ack_dly = 3;
            $display("done timeout");
        end
    endtask
    task t_clk;
        reg p;
        integer t;
        for (i = 1; i < 3; i = i + 1) begin
            axw(`OFS_CTRL, i, `RESP_OKAY);
            repeat (4) @(posedge clk_sys);
            `CHK({cclk_oe_n, bclk_oe_n}, ~i[1:0], "clock select")
            p = i[0] ? bclk_o : cclk_o;
            t = 0;
            repeat (8) begin
                @(posedge clk_sys);
                t = t + ((i[0] ? bclk_o : cclk_o) != p);
                p = i[0] ? bclk_o : cclk_o;
            end
            `CHK(t == 8, 1'h1, "half rate toggle")
        end
        axw(`OFS_CTRL, 32'h00000000, `RESP_OKAY);
        $display("done clocks");
    endtask
    task t_init;
        begin
            axw(`OFS_CTRL, 32'h00000004, `RESP_OKAY);
            supply_low <= 1'h1;
            repeat (6) @(posedge clk_sys);
            `CHK({init_oe_n, core_reset}, 2'h1, "supply init")
            axw(`OFS_CTRL, 32'h00000008, `RESP_OKAY);
            repeat (4) @(posedge clk_sys);
            `CHK(init_oe_n, 1'h1, "init cut")
            supply_low <= 1'h0;
            init_tb_n <= 1'h0;
            repeat (6) @(posedge clk_sys);
            `CHK(core_reset, 1'h1, "init received")
            // second reset in mid-run clears the receive option
            rst <= 1'h1;
            repeat (2) @(posedge clk_sys);
            rst <= 1'h0;
            repeat (6) @(posedge clk_sys);
            `CHK(core_reset, 1'h0, "init ignored")
            axr(`OFS_CTRL, `RESP_OKAY);
            `CHK(rd, 32'h00000000, "ctrl after reset")
            init_tb_n <= 1'h1;
            $display("done init");
        end
    endtask
    task t_dma;
        begin
            u_bus_far_end.dma(1'h1, 24'h000010, 16'hC35A, q);
            u_bus_far_end.dma(1'h0, 24'h000010, 16'h0000, q);
            `CHK(q, 16'hC35A, "dma readback")
            axr(`OFS_INT_STAT, `RESP_OKAY);
            `CHK(rd[`INT_DMAWR], 1'h1, "dma write event")
            $display("done dma");
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d failures %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // 50 ns clock
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    // main sequence
    initial begin
        {rst, supply_low, init_tb_n} = 3'h5;
        {aw_v, w_v, b_r, ar_v, r_r} = 5'h00;
        {aw_a, ar_a, w_d} = 48'h000000000000;
        failures = 0;
        tests_run = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        t_reset;
        t_kinds;
        t_byte;
        t_hi;
        t_tmo;
        t_clk;
        t_init;
        t_dma;
        end_sim;
    end
    // tests need under 1000 cycles; 20000 means a hang
    initial begin
        #1000000;
        failures = failures + 1;
        end_sim;
    end
endmodule // ieee796_bus_master_interface_tb_top
